// File: core/fdt_pkg.sv
// Constants and types shared by the fetch deadman timer files
`default_nettype none
package fdt_pkg;

   // ********************************
   // APB register map (byte offsets)
   // ********************************
   localparam int         ADDR_W     = 8;
   localparam logic [7:0] OFS_CON    = 8'h00;
   localparam logic [7:0] OFS_PRECLR = 8'h04;
   localparam logic [7:0] OFS_CLR    = 8'h08;
   localparam logic [7:0] OFS_STAT   = 8'h0C;
   localparam logic [7:0] OFS_CNTL   = 8'h10;
   localparam logic [7:0] OFS_CNTH   = 8'h14;
   localparam logic [7:0] OFS_PSCNTL = 8'h18;
   localparam logic [7:0] OFS_PSCNTH = 8'h1C;
   localparam logic [7:0] OFS_HOLD   = 8'h20;

   // ********************************
   // Field positions
   // ********************************
   localparam int ON_BIT   = 15;
   localparam int KEY1_LSB = 8;
   localparam int KEY2_LSB = 0;
   localparam int BAD_FIRST_KEY_FLAG_BIT = 7;
   localparam int BAD_SECOND_KEY_FLAG_BIT = 6;
   localparam int EVT_BIT  = 5;
   localparam int WIN_BIT  = 0;
   localparam int HALF_W   = 16;
   localparam int CNT_W    = 32;

   // ********************************
   // Key patterns and reset values
   // ********************************
   localparam logic [7:0]  KEY_FIRST  = 8'h40;
   localparam logic [7:0]  KEY_SECOND = 8'h08;
   localparam logic [7:0]  KEY_RST    = 8'h00;
   localparam logic [31:0] CNT_RST    = 32'h0000_0000;
   localparam logic [15:0] HALF_RST   = 16'h0000;
   localparam logic [31:0] DATA_RST   = 32'h0000_0000;

   // ********************************
   // Configuration load sequence
   // ********************************
   typedef enum logic {
      CFG_LOAD,
      CFG_DONE
   } fdt_cfg_t;

endpackage : fdt_pkg
`default_nettype wire

// File: core/fdt_fetch_counter.sv
// 32-bit fetch counter that stops at the match value
`default_nettype none
module fdt_fetch_counter (
   input  wire logic                      pclk,    // System clock
   input  wire logic                      presetn, // Async reset, active low
   input  wire logic                      run,     // Qualified fetch this cycle
   input  wire logic                      clear,   // Restart count at zero
   input  wire logic [fdt_pkg::CNT_W-1:0] match,   // Match value
   output logic      [fdt_pkg::CNT_W-1:0] count,   // Live count
   output logic                           expired  // Count equals match
);
   import fdt_pkg::*;

   // ********************************
   // Counter
   // ********************************
   // Stops at match so the expiry stays visible
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= CNT_RST;
      end else if (clear) begin
         count <= CNT_RST;
      end else if (run && !expired) begin
         count <= count + 32'h0000_0001;
      end
   end

   assign expired = (count == match);

   // ********************************
   // Checks
   // ********************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_count_step: assert property (run && !clear && !expired |=> count == $past(count) + 32'h1)
      else $error("count did not step on a fetch");
   a_count_stop: assert property (expired && !clear ##1 !clear [*2] |-> $stable(count))
      else $error("count moved past the match");
   c_expiry: cover property (!expired ##1 expired);

endmodule : fdt_fetch_counter
`default_nettype wire

// File: core/fdt_deadman.sv
// Top of the fetch deadman timer: APB registers, keys and flags
//
// How it works
// - Count each instruction fetch on pclk
// - Hold the count while the core sleeps
// - 32-bit counter, match from two halves
// - Enable by fuse or software on bit
// - Software on bit obeys only without fuse disable
// - First key 0x40 in upper byte arms
// - Wrong first key sets bad first flag
// - First key cleared by reset event, good clear
// - Second key 0x08 clears keys and counter
// - Wrong second key flags, keeps first, stores
// - Second key cleared by reset event
// - Status bit 7 bad first, 6 second
// - Status bit 5 on expiry or bad key
// - Status bit 0 shows clear window open
// - Low count register reads count low half
// - High count register reads count high half
// - Low mirror shows low fuse match word
// - Event drives the interrupt to the core
// - Hold register captures high half on read
// - High mirror shows high fuse match word
`default_nettype none
module fdt_deadman (
   input  wire logic                       pclk,                 // System clock, 50 MHz
   input  wire logic                       presetn,              // Async reset, active low
   input  wire logic                       psel,                 // APB select
   input  wire logic                       penable,              // APB access phase
   input  wire logic                       pwrite,               // APB write
   input  wire logic [fdt_pkg::ADDR_W-1:0] paddr,                // APB byte address
   input  wire logic [31:0]                pwdata,               // APB write data
   output logic      [31:0]                prdata,               // APB read data
   output logic                            pready,               // APB ready
   output logic                            pslverr,              // APB error, unmapped
   input  wire logic                       fetch_strobe,         // Core fetched an instruction
   input  wire logic                       cpu_sleep,            // Core in sleep state
   input  wire logic                       timer_reset_event,    // Timer reset event pulse
   input  wire logic                       fuse_timer_enable,    // Fuse enables timer
   input  wire logic                       fuse_timer_disable,   // Fuse locks software on bit
   input  wire logic [15:0]                fuse_match_low_word,  // Fuse match low word
   input  wire logic [15:0]                fuse_match_high_word, // Fuse match high word
   output logic                            malfunction_irq       // Event to the core
);
   import fdt_pkg::*;

   // ********************************
   // Declarations
   // ********************************
   fdt_cfg_t    cfg_state;
   logic        fuse_en;
   logic        fuse_dis;
   logic [15:0] match_lo;
   logic [15:0] match_hi;
   logic        sw_on;
   logic        active;
   logic [7:0]  first_key_field;
   logic [7:0]  second_key_field;
   logic        bad_first_key_flag;
   logic        bad_second_key_flag;
   logic        timeout_event_flag;
   logic        clear_window_open;
   logic [15:0] upper_count_captured;
   logic [31:0] count;
   logic        expired;
   logic        run;
   logic        wr_acc;
   logic        rd_acc;
   logic        rd_setup;
   logic        mapped;
   logic        pre_wr;
   logic        clr_wr;
   logic        con_wr;
   logic [7:0]  wr_k1;
   logic [7:0]  wr_k2;
   logic        bad_first_key_flag_set;
   logic        bad_second_key_flag_set;
   logic        good_clear;
   logic        hw_clear;
   logic        evt_set;
   logic [15:0] rd_mux;

   // ********************************
   // Configuration load
   // ********************************
   // Fuse words are caught by a clocked step after release,
   // never by the async reset itself
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_state <= CFG_LOAD;
      end else begin
         unique case (cfg_state)
            CFG_LOAD: cfg_state <= CFG_DONE;
            CFG_DONE: cfg_state <= CFG_DONE;
         endcase
      end
   end

   // Mirrors stay fixed until the next power-on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_lo <= HALF_RST;
         match_hi <= HALF_RST;
         fuse_en  <= 1'b0;
         fuse_dis <= 1'b0;
      end else if (cfg_state == CFG_LOAD) begin
         match_lo <= fuse_match_low_word;
         match_hi <= fuse_match_high_word;
         fuse_en  <= fuse_timer_enable;
         fuse_dis <= fuse_timer_disable;
      end
   end

   // ********************************
   // APB decode
   // ********************************
   // Zero wait states: read data is staged in the setup cycle
   assign pready   = 1'b1;
   assign wr_acc   = psel && penable && pwrite;
   assign rd_acc   = psel && penable && !pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign pre_wr   = wr_acc && (paddr == OFS_PRECLR);
   assign clr_wr   = wr_acc && (paddr == OFS_CLR);
   assign con_wr   = wr_acc && (paddr == OFS_CON);
   assign wr_k1    = pwdata[KEY1_LSB +: 8];
   assign wr_k2    = pwdata[KEY2_LSB +: 8];

   // Unmapped addresses answer with an error, writes dropped
   always_comb begin
      unique case (paddr)
         OFS_CON, OFS_PRECLR, OFS_CLR,
         OFS_STAT, OFS_CNTL, OFS_CNTH,
         OFS_PSCNTL, OFS_PSCNTH, OFS_HOLD: mapped = 1'b1;
         default:                          mapped = 1'b0;
      endcase
   end

   assign pslverr = psel && penable && !mapped;

   // ********************************
   // Enable
   // ********************************
   // Fuse lock leaves the on bit frozen at its last value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_on <= 1'b0;
      end else if (con_wr && !fuse_dis) begin
         sw_on <= pwdata[ON_BIT];
      end
   end

   // Nothing runs before the fuse words are loaded
   assign active = (cfg_state == CFG_DONE) && (fuse_en || sw_on);
   assign clear_window_open = active;

   // ********************************
   // Key sequence
   // ********************************
   // A second key only counts after an armed first key
   assign bad_first_key_flag_set   = pre_wr && (wr_k1 != KEY_FIRST);
   assign good_clear = clr_wr && (first_key_field == KEY_FIRST) && (wr_k2 == KEY_SECOND);
   assign bad_second_key_flag_set   = clr_wr && !good_clear;
   assign hw_clear   = timer_reset_event || good_clear;

   // First key field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_key_field <= KEY_RST;
      end else if (hw_clear) begin
         first_key_field <= KEY_RST;
      end else if (pre_wr) begin
         first_key_field <= wr_k1;
      end
   end

   // Second key field keeps a bad value for software to see
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         second_key_field <= KEY_RST;
      end else if (hw_clear) begin
         second_key_field <= KEY_RST;
      end else if (clr_wr) begin
         second_key_field <= wr_k2;
      end
   end

   // ********************************
   // Status flags
   // ********************************
   // Set wins over clear so no bad key is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bad_first_key_flag <= 1'b0;
      end else if (bad_first_key_flag_set) begin
         bad_first_key_flag <= 1'b1;
      end else if (hw_clear) begin
         bad_first_key_flag <= 1'b0;
      end
   end

   // Bad second key flag, same policy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bad_second_key_flag <= 1'b0;
      end else if (bad_second_key_flag_set) begin
         bad_second_key_flag <= 1'b1;
      end else if (hw_clear) begin
         bad_second_key_flag <= 1'b0;
      end
   end

   // Expiry or any bad key raises the event; the expiry term
   // yields to a clear, since the count restarts at that same edge
   assign evt_set = (active && expired && !hw_clear) || bad_first_key_flag_set || bad_second_key_flag_set;

   // Held until a reset event or a good clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_event_flag <= 1'b0;
      end else if (evt_set) begin
         timeout_event_flag <= 1'b1;
      end else if (hw_clear) begin
         timeout_event_flag <= 1'b0;
      end
   end

   // Level interrupt straight from the flag register
   assign malfunction_irq = timeout_event_flag;

   // ********************************
   // Counter
   // ********************************
   // No fetches arrive in sleep, gated anyway
   assign run = active && fetch_strobe && !cpu_sleep;

   fdt_fetch_counter u_counter (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (run),
      .clear   (hw_clear),
      .match   ({match_hi, match_lo}),
      .count   (count),
      .expired (expired)
   );

   // ********************************
   // Hold register
   // ********************************
   // Either count read snaps the high half
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_count_captured <= HALF_RST;
      end else if (rd_acc && (paddr == OFS_CNTL || paddr == OFS_CNTH)) begin
         upper_count_captured <= count[CNT_W-1:HALF_W];
      end
   end

   // ********************************
   // Read data
   // ********************************
   // Read mux, reserved bits zero
   always_comb begin
      rd_mux = HALF_RST;
      unique case (paddr)
         OFS_CON: rd_mux[ON_BIT] = sw_on;
         OFS_PRECLR: rd_mux[KEY1_LSB +: 8] = first_key_field;
         OFS_CLR: rd_mux[KEY2_LSB +: 8] = second_key_field;
         OFS_STAT: begin
            rd_mux[BAD_FIRST_KEY_FLAG_BIT] = bad_first_key_flag;
            rd_mux[BAD_SECOND_KEY_FLAG_BIT] = bad_second_key_flag;
            rd_mux[EVT_BIT]  = timeout_event_flag;
            rd_mux[WIN_BIT]  = clear_window_open;
         end
         OFS_CNTL: rd_mux = count[HALF_W-1:0];
         OFS_CNTH: rd_mux = count[CNT_W-1:HALF_W];
         OFS_PSCNTL: rd_mux = match_lo;
         OFS_PSCNTH: rd_mux = match_hi;
         OFS_HOLD: rd_mux = upper_count_captured;
         default: rd_mux = HALF_RST;
      endcase
   end

   // Registered in setup so the count is the one at that edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= DATA_RST;
      end else if (rd_setup) begin
         prdata <= {HALF_RST, rd_mux};
      end
   end

   // ********************************
   // Checks
   // ********************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_sleep_hold: assert property (cpu_sleep && !hw_clear |=> $stable(count))
      else $error("count moved during sleep");
   a_on_locked: assert property (fuse_dis && cfg_state == CFG_DONE |=> $stable(sw_on))
      else $error("on bit changed under fuse lock");
   a_bad_first: assert property (pre_wr && wr_k1 != KEY_FIRST |=> bad_first_key_flag && timeout_event_flag)
      else $error("bad first key not flagged");
   a_first_clear: assert property (timer_reset_event |=> first_key_field == KEY_RST)
      else $error("first key survived reset event");
   a_good_clear: assert property (good_clear |=> count == CNT_RST && first_key_field == KEY_RST
                                  && second_key_field == KEY_RST)
      else $error("good clear did not restart");
   a_bad_second: assert property (bad_second_key_flag_set && !timer_reset_event
                                  |=> bad_second_key_flag && first_key_field == $past(first_key_field)
                                  && second_key_field == $past(wr_k2))
      else $error("bad second key mishandled");
   a_second_clear: assert property (timer_reset_event |=> second_key_field == KEY_RST)
      else $error("second key survived reset event");
   a_expire_evt: assert property (active && expired && !hw_clear ##1 !hw_clear |-> timeout_event_flag [*2])
      else $error("expiry did not hold the event");
   a_irq_level: assert property (evt_set |=> malfunction_irq)
      else $error("interrupt missing after event");
   a_read_low: assert property (rd_setup && paddr == OFS_CNTL |=> prdata[15:0] == $past(count[15:0]))
      else $error("low count read wrong");
   a_hold_snap: assert property (rd_acc && paddr == OFS_CNTH
                                 |=> upper_count_captured == $past(count[31:16]))
      else $error("hold register not captured");
   a_hold_low: assert property (rd_acc && paddr == OFS_CNTL |=> upper_count_captured == $past(count[31:16]))
      else $error("hold register not captured on low read");
   a_mirror_fix: assert property (cfg_state == CFG_DONE |=> $stable(match_lo) && $stable(match_hi))
      else $error("match mirror changed");
   a_evt_clear: assert property (good_clear |=> !timeout_event_flag)
      else $error("good clear left the event set");
   a_flag_hold: assert property (bad_first_key_flag && !hw_clear |=> bad_first_key_flag)
      else $error("bad first flag lost");

   c_good_clear: cover property (pre_wr && !bad_first_key_flag_set ##[1:20] good_clear);
   c_bad_first: cover property (bad_first_key_flag_set);
   c_sleep_hold: cover property (cpu_sleep && fetch_strobe && active);
   c_bad_second: cover property (bad_second_key_flag_set);
   c_expire_irq: cover property (active && expired ##1 malfunction_irq);

endmodule : fdt_deadman
`default_nettype wire

// File: tb/fdt_core_model.sv
// Processor core model: instruction fetch strobes and sleep state
`default_nettype none
module fdt_core_model (
   input  wire logic pclk,         // System clock
   output logic      fetch_strobe, // One fetch per high cycle
   output logic      cpu_sleep     // Core asleep
);
   timeunit 1ns;
   timeprecision 1ps;

   // ********************************
   // Idle core: awake, not fetching
   // ********************************
   initial begin
      fetch_strobe = 1'b0;
      cpu_sleep    = 1'b0;
   end

   // Burst of n fetch cycles; asleep=1 is a commanded fault with stray strobes
   task automatic burst(input int n, input bit asleep);
      repeat (n) begin
         @(posedge pclk);
         fetch_strobe <= 1'b1;
         cpu_sleep    <= asleep;
      end
      @(posedge pclk);
      fetch_strobe <= 1'b0;
      cpu_sleep    <= 1'b0;
   endtask : burst
endmodule : fdt_core_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the fetch deadman timer
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fdt_pkg::*;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        fetch_strobe, cpu_sleep, timer_reset_event, malfunction_irq;
   logic        fuse_timer_enable, fuse_timer_disable;
   logic [15:0] fuse_match_low_word, fuse_match_high_word;
   int          fail_count;
   int          tests_run;

   // ********************************
   // Clock, design and core model
   // ********************************
   initial pclk = 1'b0;
   always #10 pclk = ~pclk;

   fdt_deadman i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fetch_strobe(fetch_strobe), .cpu_sleep(cpu_sleep), .timer_reset_event(timer_reset_event),
      .fuse_timer_enable(fuse_timer_enable), .fuse_timer_disable(fuse_timer_disable),
      .fuse_match_low_word(fuse_match_low_word), .fuse_match_high_word(fuse_match_high_word),
      .malfunction_irq(malfunction_irq));

   fdt_core_model i_core (.pclk(pclk), .fetch_strobe(fetch_strobe), .cpu_sleep(cpu_sleep));

   // ********************************
   // Shared tasks
   // ********************************
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : check

   // One APB transfer; waits on pready under a bound, never assumes latency
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) check("pready", 32'h1, 32'h0);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(a, 1'b1, d, q, e);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
      logic [31:0] q;
      logic        e;
      apb(a, 1'b0, DATA_RST, q, e);
      check(name, exp, q);
      check({name, " error"}, 32'h0, {31'h0, e});
   endtask : rd_chk

   // Straps are valid throughout reset so the load edge sees them
   task automatic rst(input logic en, input logic dis, input logic [15:0] lo, input logic [15:0] hi);
      @(posedge pclk);
      presetn              <= 1'b0;
      fuse_timer_enable    <= en;
      fuse_timer_disable   <= dis;
      fuse_match_low_word  <= lo;
      fuse_match_high_word <= hi;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask : rst

   task automatic pulse_reset_event();
      @(posedge pclk);
      timer_reset_event <= 1'b1;
      @(posedge pclk);
      timer_reset_event <= 1'b0;
   endtask : pulse_reset_event

   // ********************************
   // Scenarios
   // ********************************
   task automatic t_reset_values();
      logic [31:0] q;
      logic        e;
      rd_chk(OFS_CON, 32'h0, "control");
      rd_chk(OFS_STAT, 32'h1, "status");
      rd_chk(OFS_CNTL, 32'h0, "count low");
      rd_chk(OFS_CNTH, 32'h0, "count high");
      rd_chk(OFS_HOLD, 32'h0, "hold");
      rd_chk(OFS_PSCNTL, 32'h5, "mirror low");
      rd_chk(OFS_PSCNTH, 32'h0, "mirror high");
      apb(8'h24, 1'b0, DATA_RST, q, e);
      check("unmapped data", 32'h0, q);
      check("unmapped error", 32'h1, {31'h0, e});
      $display("test reset_values done");
   endtask : t_reset_values

   // Stray strobes during sleep must not count
   task automatic t_count_sleep();
      i_core.burst(2, 1'b0);
      i_core.burst(3, 1'b1);
      i_core.burst(1, 1'b0);
      rd_chk(OFS_CNTL, 32'h3, "count after sleep");
      $display("test count_sleep done");
   endtask : t_count_sleep

   // Overrun past the match value; counter parks there
   task automatic t_expire();
      i_core.burst(6, 1'b0);
      rd_chk(OFS_CNTL, 32'h5, "count at match");
      rd_chk(OFS_STAT, 32'h21, "status expired");
      check("irq expired", 32'h1, {31'h0, malfunction_irq});
      rd_chk(OFS_CNTH, 32'h0, "count high");
      $display("test expire done");
   endtask : t_expire

   task automatic t_good_clear();
      wr(OFS_PRECLR, 32'h4000);
      rd_chk(OFS_PRECLR, 32'h4000, "first key");
      wr(OFS_CLR, 32'h08);
      rd_chk(OFS_CNTL, 32'h0, "count cleared");
      rd_chk(OFS_PRECLR, 32'h0, "first cleared");
      rd_chk(OFS_CLR, 32'h0, "second cleared");
      rd_chk(OFS_STAT, 32'h1, "status cleared");
      check("irq cleared", 32'h0, {31'h0, malfunction_irq});
      wr(OFS_CNTL, 32'hFFFF);
      rd_chk(OFS_CNTL, 32'h0, "read-only count");
      $display("test good_clear done");
   endtask : t_good_clear

   task automatic t_bad_keys();
      wr(OFS_PRECLR, 32'h1200);
      rd_chk(OFS_STAT, 32'hA1, "bad first");
      pulse_reset_event();
      rd_chk(OFS_STAT, 32'h1, "event cleared");
      rd_chk(OFS_PRECLR, 32'h0, "first reset");
      wr(OFS_PRECLR, 32'h4000);
      wr(OFS_CLR, 32'h33);
      rd_chk(OFS_STAT, 32'h61, "bad second");
      rd_chk(OFS_PRECLR, 32'h4000, "first kept");
      rd_chk(OFS_CLR, 32'h33, "second stored");
      pulse_reset_event();
      rd_chk(OFS_CLR, 32'h0, "second reset");
      rd_chk(OFS_PRECLR, 32'h0, "first reset");
      wr(OFS_CLR, 32'h08);
      rd_chk(OFS_STAT, 32'h61, "out of order");
      pulse_reset_event();
      $display("test bad_keys done");
   endtask : t_bad_keys

   // Software on bit: obeyed without fuse lock, frozen with it
   task automatic t_fuse();
      rst(1'b0, 1'b0, 16'h0002, 16'h00A5);
      rd_chk(OFS_STAT, 32'h0, "window closed");
      i_core.burst(2, 1'b0);
      rd_chk(OFS_CNTL, 32'h0, "idle count");
      wr(OFS_CON, 32'h8000);
      rd_chk(OFS_CON, 32'h8000, "on bit");
      i_core.burst(1, 1'b0);
      rd_chk(OFS_CNTL, 32'h1, "software count");
      rd_chk(OFS_PSCNTH, 32'hA5, "mirror high");
      rst(1'b0, 1'b1, 16'h0002, 16'h0000);
      wr(OFS_CON, 32'h8000);
      rd_chk(OFS_CON, 32'h0, "locked on bit");
      i_core.burst(2, 1'b0);
      rd_chk(OFS_CNTL, 32'h0, "locked count");
      $display("test fuse done");
   endtask : t_fuse

   // ********************************
   // Verdict and main sequence
   // ********************************
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   // Watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge pclk);
      fail_count++;
      finish_test();
   end

   initial begin
      fail_count        = 0;
      tests_run         = 0;
      presetn           = 1'b0;
      psel              = 1'b0;
      penable           = 1'b0;
      pwrite            = 1'b0;
      paddr             = 8'h00;
      pwdata            = DATA_RST;
      timer_reset_event = 1'b0;
      fuse_timer_enable = 1'b1;
      fuse_timer_disable   = 1'b0;
      fuse_match_low_word  = 16'h0005;
      fuse_match_high_word = 16'h0000;
      rst(1'b1, 1'b0, 16'h0005, 16'h0000);
      t_reset_values();
      t_count_sleep();
      t_expire();
      t_good_clear();
      t_bad_keys();
      t_fuse();
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
